// File: hdl/rtccr_prescale.v
// Second prescaler for the trimmed timebase: half-second flag,
// second pulse and rollover window.
// Assumes inc is 0, 1 or 2 timebase steps per core clock cycle.
`timescale 1ns/1ps
`default_nettype none
module rtccr_prescale #(
   parameter CNT_W   = 15,
   parameter ROLL_WIN = 4
) (
   // Clock and reset
   input  wire             core_clk,
   input  wire             rst,
   input  wire             clkEn,
   // Timebase steps
   input  wire [1:0]       inc,
   input  wire             clear,
   // Status
   output reg              secPulse_r,
   output wire             half_second_flag,
   output reg              rollPend_r
);
   localparam [CNT_W-1:0] ROLL_START = {CNT_W{1'b1}} - ROLL_WIN[CNT_W-1:0] + {{(CNT_W-1){1'b0}}, 1'b1};

   reg  [CNT_W-1:0] cnt_r;
   wire [CNT_W:0]   sum_nxt = {1'b0, cnt_r} + {{(CNT_W-1){1'b0}}, inc};

   assign half_second_flag = cnt_r[CNT_W-1];

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r      <= {CNT_W{1'b0}};
         secPulse_r <= 1'b0;
         rollPend_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (clear)
         begin
            cnt_r      <= {CNT_W{1'b0}};
            secPulse_r <= 1'b0;
         end
         else
         begin
            cnt_r      <= sum_nxt[CNT_W-1:0];
            secPulse_r <= sum_nxt[CNT_W];
         end
         // Ripple window just before and at the second rollover
         rollPend_r <= (cnt_r >= ROLL_START) | secPulse_r;
      end
   end
endmodule
`default_nettype wire

// File: hdl/rtccr_regs.vh
// Offsets, field positions, reset values and timing counts of the
// clock and calendar control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef RTCCR_REGS_VH
`define RTCCR_REGS_VH

// Register byte offsets
`define RTCCR_CTRL_OFS      4'h0
`define RTCCR_TIME_OFS      4'h4

// Control register field positions
`define RTCCR_TRIM_MSB      25
`define RTCCR_TRIM_LSB      16
`define RTCCR_ENABLE_BIT    15
`define RTCCR_IDLE_BIT      13
`define RTCCR_PINSEL_BIT    7
`define RTCCR_RUN_BIT       6
`define RTCCR_UNLOCK_BIT    3
`define RTCCR_ROLL_BIT      2
`define RTCCR_HALF_BIT      1
`define RTCCR_OE_BIT        0

// Time register seconds fields
`define RTCCR_SECT_MSB      14
`define RTCCR_SECT_LSB      12
`define RTCCR_SECU_MSB      11
`define RTCCR_SECU_LSB      8

// Reset values
`define RTCCR_TRIM_RST      10'h000
`define RTCCR_BIT_RST       1'b0

// Timing
`define RTCCR_CLK_MHZ       250
`define RTCCR_XTAL_HZ       32768
`define RTCCR_XTAL_NS       30518
`define RTCCR_STALL_NS      (2 * `RTCCR_XTAL_NS)
`define RTCCR_STALL_CYC     ((`RTCCR_STALL_NS * `RTCCR_CLK_MHZ) / 1000)
`define RTCCR_TICK_W        15
`define RTCCR_ROLL_WIN      4

`endif

// File: hdl/rtccr_seconds.v
// BCD seconds counter 00..59 with software load and minute pulse.
// Assumes secPulse is a one-cycle pulse once per trimmed second.
`timescale 1ns/1ps
`default_nettype none
module rtccr_seconds (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   input  wire       clkEn,
   // Counting and load
   input  wire       secPulse,
   input  wire       load,
   input  wire [2:0] loadTens,
   input  wire [3:0] loadUnits,
   // Value
   output reg  [2:0] tens_r,
   output reg  [3:0] units_r,
   output reg        minutePulse_r
);
   wire atNine  = (units_r == 4'h9);
   wire atFifty = (tens_r == 3'h5);

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         tens_r        <= 3'h0;
         units_r       <= 4'h0;
         minutePulse_r <= 1'b0;
      end
      else if (clkEn)
      begin
         minutePulse_r <= 1'b0;
         if (load)
         begin
            tens_r  <= loadTens;
            units_r <= loadUnits;
         end
         else if (secPulse)
         begin
            if (atNine)
            begin
               units_r <= 4'h0;
               if (atFifty)
               begin
                  tens_r        <= 3'h0;
                  minutePulse_r <= 1'b1;
               end
               else
               begin
                  tens_r <= tens_r + 3'h1;
               end
            end
            else
            begin
               units_r <= units_r + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/rtccr_top.v
// Control and status register of the clock and calendar block, with the
// trimmed crystal timebase, seconds counter and pin output logic.
// Assumes a classic Wishbone master, a crystal level sampled on core_clk,
// and idle and write-sequence permission levels from the power logic.
`timescale 1ns/1ps
`default_nettype none
`include "rtccr_regs.vh"
module rtccr_top #(
   parameter ADDR_W    = 4,
   parameter TRIM_W    = 10,
   parameter STALL_CYC = `RTCCR_STALL_CYC
) (
   // Clock, reset and clock enable
   input  wire              core_clk,
   input  wire              rst,
   input  wire              clkEn,
   // Wishbone slave
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   input  wire              wb_we_i,
   input  wire [ADDR_W-1:0] wb_adr_i,
   input  wire [3:0]        wb_sel_i,
   input  wire [31:0]       wb_dat_i,
   output reg  [31:0]       wb_dat_o,
   output wire              wb_ack_o,
   // Crystal timebase level
   input  wire              xtalIn,
   // Power management
   input  wire              idleMode,
   input  wire              writeSeqEnable,
   output wire              busClkEnable,
   // Alarm and pin
   input  wire              alarmPulse,
   output reg               pinOut_r,
   output reg               pinOutEn_r
);
   localparam CNT_W = `RTCCR_TICK_W;
   localparam SW    = 16;

   // Control fields
   reg  [TRIM_W-1:0] trim_r;
   reg               enable_r;
   reg               idleHalt_r;
   reg               pinSel_r;
   reg               unlock_r;
   reg               pinOe_r;
   reg               timebaseRunning_r;

   // Bus state
   reg               ack_r;

   // Crystal tracking
   reg               xtalPrev_r;
   reg  [SW-1:0]     stallCnt_r;

   // Trim engine
   reg  [TRIM_W-1:0] trimLeft_r;
   reg               trimNeg_r;
   reg  [1:0]        inc_nxt;

   // Timebase status
   wire              secPulse;
   wire              half_second_flag;
   wire              rollPend;
   wire [2:0]        secTens;
   wire [3:0]        secUnits;
   wire              minutePulse;

   // Decode of a byte address onto one register slot
   function hitReg;
      input [ADDR_W-1:0] adr;
      input [ADDR_W-1:0] ofs;
      begin
         hitReg = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
      end
   endfunction

   // Byte-lane merge of write data over the current value
   function [31:0] mergeSel;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0]  sel;
      integer i;
      begin
         mergeSel = oldVal;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (sel[i])
            begin
               mergeSel[i*8 +: 8] = newVal[i*8 +: 8];
            end
         end
      end
   endfunction

   // Bus clock gating in idle; bus side state freezes with it
   assign busClkEnable = ~(idleHalt_r & idleMode);
   wire busEn = clkEn & busClkEnable;

   wire req      = wb_cyc_i & wb_stb_i;
   wire access   = req & ack_r & busEn;
   wire ctrlHit  = hitReg(wb_adr_i, `RTCCR_CTRL_OFS);
   wire timeHit  = hitReg(wb_adr_i, `RTCCR_TIME_OFS);
   wire ctrlWr   = access & wb_we_i & ctrlHit;
   wire timeWr   = access & wb_we_i & timeHit;

   assign wb_ack_o = ack_r;

   // Control register view; unused bits tied low
   wire [31:0] ctrlView =
   {
      6'h00,
      trim_r,
      enable_r,
      1'b0,
      idleHalt_r,
      5'h00,
      pinSel_r,
      timebaseRunning_r,
      2'b00,
      unlock_r,
      rollPend,
      half_second_flag,
      pinOe_r
   };

   wire [31:0] timeView =
   {
      17'h00000,
      secTens,
      secUnits,
      8'h00
   };

   wire [31:0] ctrlWrVal = mergeSel(ctrlView, wb_dat_i, wb_sel_i);

   // Seconds load lands only while unlocked, and only through its lane
   wire secLoad = timeWr & unlock_r & wb_sel_i[1];

   // Bus answer: data latched at request, ack one cycle later
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_r    <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else if (busEn)
      begin
         ack_r <= req & ~ack_r;
         if (req & ~ack_r)
         begin
            if (wb_we_i)
            begin
               wb_dat_o <= 32'h00000000;
            end
            else if (ctrlHit)
            begin
               wb_dat_o <= ctrlView;
            end
            else if (timeHit)
            begin
               wb_dat_o <= timeView;
            end
            else
            begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end

   // Control register writes; status bits of the write are dropped
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         trim_r     <= `RTCCR_TRIM_RST;
         enable_r   <= `RTCCR_BIT_RST;
         idleHalt_r <= `RTCCR_BIT_RST;
         pinSel_r   <= `RTCCR_BIT_RST;
         unlock_r   <= `RTCCR_BIT_RST;
         pinOe_r    <= `RTCCR_BIT_RST;
      end
      else if (busEn & ctrlWr)
      begin
         trim_r     <= ctrlWrVal[`RTCCR_TRIM_MSB:`RTCCR_TRIM_LSB];
         idleHalt_r <= ctrlWrVal[`RTCCR_IDLE_BIT];
         pinSel_r   <= ctrlWrVal[`RTCCR_PINSEL_BIT];
         pinOe_r    <= ctrlWrVal[`RTCCR_OE_BIT];
         // Lock state before this write decides
         if (unlock_r)
         begin
            enable_r <= ctrlWrVal[`RTCCR_ENABLE_BIT];
         end
         // Clearing always allowed, setting needs permission
         unlock_r <= ctrlWrVal[`RTCCR_UNLOCK_BIT] & (unlock_r | writeSeqEnable);
      end
   end

   // Crystal edge detection; input is already synchronous to core_clk
   wire xtalEdge = xtalIn & ~xtalPrev_r;

   // Running means enabled and crystal edges seen within two periods
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         xtalPrev_r        <= 1'b0;
         stallCnt_r        <= {SW{1'b0}};
         timebaseRunning_r <= 1'b0;
      end
      else if (clkEn)
      begin
         xtalPrev_r <= xtalIn;
         if (xtalEdge)
         begin
            stallCnt_r <= {SW{1'b0}};
         end
         else if (stallCnt_r != STALL_CYC[SW-1:0])
         begin
            stallCnt_r <= stallCnt_r + {{(SW-1){1'b0}}, 1'b1};
         end
         timebaseRunning_r <= enable_r & (stallCnt_r != STALL_CYC[SW-1:0]);
      end
   end

   // Magnitude of the signed trim; most negative code gives 512
   wire [TRIM_W-1:0] trimMag = trim_r[TRIM_W-1] ? (~trim_r + {{(TRIM_W-1){1'b0}}, 1'b1}) : trim_r;

   // Step count per crystal edge: swallowed, normal or doubled
   always @*
   begin
      inc_nxt = 2'd0;
      if (enable_r & xtalEdge & ~minutePulse)
      begin
         if (trimLeft_r == {TRIM_W{1'b0}})
         begin
            inc_nxt = 2'd1;
         end
         else if (trimNeg_r)
         begin
            inc_nxt = 2'd0;
         end
         else
         begin
            inc_nxt = 2'd2;
         end
      end
      else if (enable_r & xtalEdge)
      begin
         // Minute reload cycle passes the edge uncorrected
         inc_nxt = 2'd1;
      end
   end

   // Trim budget reloaded each minute, spent at the start of the minute
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         trimLeft_r <= {TRIM_W{1'b0}};
         trimNeg_r  <= 1'b0;
      end
      else if (clkEn)
      begin
         if (~enable_r)
         begin
            trimLeft_r <= {TRIM_W{1'b0}};
         end
         else if (minutePulse)
         begin
            trimLeft_r <= trimMag;
            trimNeg_r  <= trim_r[TRIM_W-1];
         end
         else if (xtalEdge & (trimLeft_r != {TRIM_W{1'b0}}))
         begin
            trimLeft_r <= trimLeft_r - {{(TRIM_W-1){1'b0}}, 1'b1};
         end
      end
   end

   rtccr_prescale #(
      .CNT_W    (CNT_W),
      .ROLL_WIN (`RTCCR_ROLL_WIN)
   ) u_prescale (
      .core_clk   (core_clk),
      .rst        (rst),
      .clkEn      (clkEn),
      .inc        (inc_nxt),
      .clear      (secLoad),
      .secPulse_r (secPulse),
      .half_second_flag    (half_second_flag),
      .rollPend_r (rollPend)
   );

   rtccr_seconds u_seconds (
      .core_clk      (core_clk),
      .rst           (rst),
      .clkEn         (clkEn),
      .secPulse      (secPulse),
      .load          (secLoad),
      .loadTens      (wb_dat_i[`RTCCR_SECT_MSB:`RTCCR_SECT_LSB]),
      .loadUnits     (wb_dat_i[`RTCCR_SECU_MSB:`RTCCR_SECU_LSB]),
      .tens_r        (secTens),
      .units_r       (secUnits),
      .minutePulse_r (minutePulse)
   );

   // Seconds clock is high in the second half of each second
   wire pinSource = pinSel_r ? half_second_flag : alarmPulse;

   // Pin driven low and released whenever its enable bit is clear
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pinOut_r   <= 1'b0;
         pinOutEn_r <= 1'b0;
      end
      else if (clkEn)
      begin
         pinOut_r   <= pinOe_r & pinSource;
         pinOutEn_r <= pinOe_r;
      end
   end
endmodule
`default_nettype wire

// File: tb/rtccr_properties.sv
// Checker for the control block: bus answers, idle gating, pin output.
// Assumes it is bound to rtccr_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rtccr_properties #(
   parameter ADDR_W    = 4,
   parameter STALL_CYC = 64
) (
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              clkEn,
   // Bus
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   // Timebase, power and pin
   input wire logic              xtalIn,
   input wire logic              idleMode,
   input wire logic              busClkEnable,
   input wire logic              pinOut_r,
   input wire logic              pinOutEn_r
);
   logic        xPrev_r;
   logic [31:0] gap_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         xPrev_r <= 1'b0;
      else
         xPrev_r <= xtalIn;
   // Saturating count of cycles since the last crystal edge
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         gap_r <= 32'h0;
      else
         gap_r <= (xtalIn & ~xPrev_r) ? 32'h0 : gap_r + {31'h0, ~&gap_r};
   sequence seqReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn && busClkEnable;
   endsequence
   sequence seqRdCtrl;
      wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0;
   endsequence
   sequence seqRdGap;
      wb_ack_o && !wb_we_i && wb_adr_i[3];
   endsequence
   AST_ACK_ANSWER: assert property (seqReq |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o && clkEn && busClkEnable |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) && clkEn && busClkEnable |=> !wb_ack_o)
      else $error("ack without request");
   AST_RSVD_ZERO: assert property (seqRdCtrl |-> (wb_dat_o & 32'hFC00_5F30) == 32'h0)
      else $error("unimplemented control bits not zero");
   AST_GAP_ZERO: assert property (seqRdGap |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_IDLE_GATE: assert property (!idleMode |-> busClkEnable)
      else $error("bus clock gated outside idle");
   AST_IDLE_FREEZE: assert property (!busClkEnable && clkEn |=> $stable(wb_ack_o) && $stable(wb_dat_o))
      else $error("bus side moved while gated");
   AST_PIN_OFF: assert property (!pinOutEn_r |-> !pinOut_r)
      else $error("pin driven while output disabled");
   AST_PIN_EN_CAUSE: assert property ($changed(pinOutEn_r) |-> $past(wb_ack_o && wb_we_i, 2))
      else $error("output enable changed without a write");
   AST_RUN_STALL: assert property (seqRdCtrl ##0 (gap_r > STALL_CYC + 8) |-> !wb_dat_o[6])
      else $error("running flag set with crystal stopped");
endmodule
bind rtccr_top rtccr_properties #(.ADDR_W(ADDR_W), .STALL_CYC(STALL_CYC)) u_rtccr_properties (
   .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .xtalIn(xtalIn), .idleMode(idleMode), .busClkEnable(busClkEnable),
   .pinOut_r(pinOut_r), .pinOutEn_r(pinOutEn_r));
`default_nettype wire

// File: tb/rtccr_tb_top.sv
// Self-checking bench for the control block: bus, pins, timebase status.
// Assumes the design files and their header are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "rtccr_regs.vh"
module tb_top;
   localparam int          STALL = 64;
   localparam logic [3:0]  CTRL  = `RTCCR_CTRL_OFS;
   localparam logic [3:0]  TIME  = `RTCCR_TIME_OFS;
   logic        coreClk = 1'b0;
   logic        rst     = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [3:0]  adr     = 4'h0;
   logic [3:0]  sel     = 4'h0;
   logic [31:0] dati    = 32'h0;
   logic        xtal    = 1'b0;
   logic        xtalRun = 1'b1;
   logic        idle    = 1'b0;
   logic        seqEn   = 1'b0;
   logic        alarm   = 1'b0;
   logic        ce      = 1'b1;
   logic [31:0] mdl     = 32'h0;
   logic [31:0] dato;
   logic        ack;
   logic        busEn;
   logic        pin;
   logic        pinEn;
   int          nMismatch = 0;
   int          cmpCount  = 0;
   int          cycN      = 0;
   rtccr_top #(.STALL_CYC(STALL)) u_rtccr_top (
      .core_clk(coreClk), .rst(rst), .clkEn(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
      .xtalIn(xtal), .idleMode(idle), .writeSeqEnable(seqEn), .busClkEnable(busEn),
      .alarmPulse(alarm), .pinOut_r(pin), .pinOutEn_r(pinEn));
   always #2 coreClk = ~coreClk;
   // Fast crystal keeps a half second near 32k cycles
   always @(posedge coreClk)
      if (xtalRun)
         xtal <= ~xtal;
   always @(posedge coreClk)
   begin
      cycN <= cycN + 1;
      if (cycN == 90000)
      begin
         nMismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (nMismatch == 0 && cmpCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmpCount++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask
   task automatic wbx(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge coreClk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dati <= d;
      do
      begin
         @(posedge coreClk);
         n++;
      end
      while (ack !== 1'b1);
      // Ack seen at the second edge after the request rises
      chkBit(n == 2, 1'b1, "ack latency");
      q = dato;
      // Idle cycle after every access
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wrCtrl(input logic [31:0] d, input logic [3:0] s, input logic e);
      logic [31:0] m;
      logic [31:0] q;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h03FF_A089;
      q = (mdl & ~m) | (d & m);
      if (!mdl[3])
         q[15] = mdl[15];
      if (!mdl[3] && !e)
         q[3] = 1'b0;
      seqEn <= e;
      wbx(1'b1, CTRL, s, d, m);
      mdl = q;
   endtask
   task automatic chkCtrl();
      logic [31:0] q;
      wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      chk(q & ~32'h0000_0046, mdl, "control");
   endtask
   task automatic waitCtrl(input int b, output logic [31:0] q);
      do
         wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      while (q[b] !== 1'b1);
   endtask
   function automatic logic [31:0] nextSec(input logic [31:0] v);
      logic [2:0] t;
      logic [3:0] u;
      t = v[14:12];
      u = v[11:8] + 4'h1;
      if (u == 4'hA)
      begin
         u = 4'h0;
         t = (t == 3'h5) ? 3'h0 : t + 3'h1;
      end
      return {17'h0, t, u, 8'h0};
   endfunction
   initial
   begin
      logic [31:0] q;
      logic [31:0] tv;
      logic [31:0] tv2;
      int          t0;
      q = $urandom(32'h84D4D10E);
      repeat (10) @(posedge coreClk);
      rst <= 1'b0;
      wbx(1'b0, TIME, 4'h0, 32'h0, q);
      chk(q, 32'h0, "time reset");
      wrCtrl(32'h0000_0046, 4'hF, 1'b0);
      wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      chk(q, 32'h0, "status write");
      wrCtrl(32'h0000_0008, 4'h1, 1'b1);
      wrCtrl(32'hFFFF_FFFF, 4'hF, 1'b0);
      chkCtrl();
      for (int i = 0; i < 24; i++)
      begin
         wrCtrl($urandom, 4'($urandom), 1'($urandom));
         chkCtrl();
      end
      for (int k = 0; k < 2; k++)
      begin
         wrCtrl((k == 1) ? 32'h0000_2000 : 32'h0, 4'h2, 1'b0);
         idle <= 1'b1;
         repeat (2) @(posedge coreClk);
         chkBit(busEn, k == 0, "bus clock gate");
         idle <= 1'b0;
      end
      wbx(1'b0, 4'h8, 4'h0, 32'h0, q);
      chk(q, 32'h0, "unmapped");
      wrCtrl(32'h0000_0008, 4'hF, 1'b1);
      wrCtrl(32'h0000_8009, 4'hF, 1'b0);
      repeat (2) @(posedge coreClk);
      q[0] = alarm;
      repeat (16)
      begin
         @(posedge coreClk);
         chkBit(pin, q[0], "alarm pin");
         q[0] = alarm;
         alarm <= 1'($urandom);
      end
      wrCtrl(32'h0000_8008, 4'h1, 1'b0);
      alarm <= 1'b1;
      repeat (3) @(posedge coreClk);
      chkBit(pin, 1'b0, "pin disabled");
      wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      chkBit(q[6], 1'b1, "running");
      xtalRun <= 1'b0;
      repeat (STALL + 20) @(posedge coreClk);
      wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      chkBit(q[6], 1'b0, "stalled");
      xtalRun <= 1'b1;
      wrCtrl(32'h0000_8089, 4'hF, 1'b0);
      tv = {17'h0, 3'($urandom % 6), 4'($urandom % 10), 8'h0};
      wbx(1'b1, TIME, 4'h2, tv, q);
      t0 = cycN;
      // Frozen clock enable delays the second by the frozen cycles
      ce <= 1'b0;
      repeat (40) @(posedge coreClk);
      ce <= 1'b1;
      wbx(1'b0, TIME, 4'h0, 32'h0, q);
      chk(q, tv, "time load");
      wbx(1'b0, CTRL, 4'h0, 32'h0, q);
      chkBit(q[1], 1'b0, "half cleared");
      chkBit(pin, 1'b0, "seconds clock low");
      waitCtrl(1, q);
      chkBit(cycN - t0 >= 32800 && cycN - t0 <= 32840, 1'b1, "half time");
      chkBit(pin, 1'b1, "seconds clock high");
      waitCtrl(2, q);
      chkBit(cycN - t0 >= 65556 && cycN - t0 <= 65584, 1'b1, "rollover time");
      do
         wbx(1'b0, TIME, 4'h0, 32'h0, q);
      while (q === tv);
      chk(q, nextSec(tv), "second step");
      wbx(1'b0, TIME, 4'h0, 32'h0, tv2);
      chk(tv2, nextSec(tv), "second read");
      wrCtrl(32'h0000_8081, 4'hF, 1'b0);
      wbx(1'b1, TIME, 4'h2, 32'h0, q);
      wbx(1'b0, TIME, 4'h0, 32'h0, q);
      chk(q, nextSec(tv), "locked time");
      complete_run();
   end
endmodule
`default_nettype wire
